// ===== rtl/uart_pkg.sv
// shared constants, register map and types of the serial port control block
package uart_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets on the apb window
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL_TWO = 8'h00;
    localparam logic [7:0] OFF_CTRL_ONE = 8'h04;
    localparam logic [7:0] OFF_BAUD = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_MASK = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h00;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    localparam logic [4:0] MASK_RESET = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // field positions of the first control register
    localparam int GPE_BIT = 7;
    localparam int NINE_BIT = 6;
    localparam int RXN_BIT = 1;
    localparam int TXN_BIT = 0;

    // sticky status / mask layout
    localparam int ST_W = 5;
    localparam int ST_RX = 0;
    localparam int ST_TXE = 1;
    localparam int ST_TXI = 2;
    localparam int ST_WAKE = 3;
    localparam int ST_OVR = 4;

    ////////////////////////////////////////////////////////////////////////////
    // timing: ticks per bit and prescale of the low speed range
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_MID = 4'h7;
    localparam logic [1:0] LOW_PRESCALE_LAST = 2'h3;
    localparam logic [10:0] LOW_FACTOR = 11'h004;
    localparam logic [10:0] HIGH_FACTOR = 11'h001;

    // second control register, most significant field first
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic baud_high_speed;
        logic address_detect_enable;
        logic rx_wake_enable;
        logic receive_irq_enable;
        logic transmit_idle_irq_enable;
        logic transmit_empty_irq_enable;
    } ctrl_two_t;

    typedef enum logic [1:0] {
        LINE_IDLE = 2'b00,
        LINE_START = 2'b01,
        LINE_DATA = 2'b11,
        LINE_STOP = 2'b10
    } line_state_t;

    // number of data bits in a frame
    function automatic logic [3:0] data_bits(input logic nine);
        return nine ? 4'h9 : 4'h8;
    endfunction : data_bits

endpackage : uart_pkg

// ===== rtl/baud_tick_gen.sv
// oversampling tick generator: sixteen ticks make one serial bit
`timescale 1ns/1ns
`default_nettype none
module baud_tick_gen #(
    parameter int DIV_W = 8
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic high_speed,
    input wire logic [DIV_W-1:0] divider,
    output logic tick
);

    logic [DIV_W-1:0] div_cnt;
    logic [1:0] pre_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // divide by n plus one
    // the >= compare keeps a lowered divider from running the counter through wrap
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_cnt <= '0;
            pre_cnt <= 2'h0;
            tick <= 1'b0;
        end else if (clear) begin
            div_cnt <= '0;
            pre_cnt <= 2'h0;
            tick <= 1'b0;
        end else if (div_cnt >= divider) begin
            div_cnt <= '0;
            if (high_speed || pre_cnt == uart_pkg::LOW_PRESCALE_LAST) begin
                pre_cnt <= 2'h0;
                tick <= 1'b1;
            end else begin
                pre_cnt <= pre_cnt + 2'h1;
                tick <= 1'b0;
            end
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
            tick <= 1'b0;
        end
    end

endmodule : baud_tick_gen
`default_nettype wire

// ===== rtl/uart_txrx_enable_addr_detect.sv
// serial port with enable control, address detection and rx wake-up, apb slave
`timescale 1ns/1ns
`default_nettype none
module uart_txrx_enable_addr_detect (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_clock_off,
    input wire logic rx_pin,
    output logic rx_pin_owned,
    output logic tx_pin,
    output logic tx_pin_oe_n,
    output logic irq
);

    uart_pkg::ctrl_two_t serial_port_control_two;
    logic global_port_enable;
    logic nine_bit_format;
    logic tx_ninth_bit;
    logic [7:0] baud_divider;
    logic [uart_pkg::ST_W-1:0] status;
    logic [uart_pkg::ST_W-1:0] mask;
    logic [uart_pkg::ST_W-1:0] events;
    logic tx_run;
    logic rx_run;
    logic baud_tick;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped addresses answer with pslverr
    logic access;
    logic mapped;
    logic wr;
    logic rd_data;
    logic [7:0] rd_mux;

    assign access = psel & penable;
    assign mapped = paddr == uart_pkg::OFF_CTRL_TWO || paddr == uart_pkg::OFF_CTRL_ONE
        || paddr == uart_pkg::OFF_BAUD || paddr == uart_pkg::OFF_DATA
        || paddr == uart_pkg::OFF_STATUS || paddr == uart_pkg::OFF_MASK;
    assign wr = access & pwrite & pstrb[0] & mapped;
    assign rd_data = access & ~pwrite & (paddr == uart_pkg::OFF_DATA);
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    // register enables combined with the global switch
    // transmitter gate
    assign tx_run = serial_port_control_two.tx_enable & global_port_enable;
    assign rx_run = serial_port_control_two.rx_enable & global_port_enable;

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    // eight rw control bits
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_port_control_two <= uart_pkg::CTRL_TWO_RESET;
            global_port_enable <= 1'b0;
            nine_bit_format <= 1'b0;
            tx_ninth_bit <= 1'b0;
            baud_divider <= uart_pkg::BAUD_RESET;
            mask <= uart_pkg::MASK_RESET;
        end else if (wr) begin
            case (paddr)
                uart_pkg::OFF_CTRL_TWO: serial_port_control_two <= pwdata[7:0];
                uart_pkg::OFF_CTRL_ONE: begin
                    global_port_enable <= pwdata[uart_pkg::GPE_BIT];
                    nine_bit_format <= pwdata[uart_pkg::NINE_BIT];
                    tx_ninth_bit <= pwdata[uart_pkg::TXN_BIT];
                end
                uart_pkg::OFF_BAUD: baud_divider <= pwdata[7:0];
                uart_pkg::OFF_MASK: mask <= pwdata[uart_pkg::ST_W-1:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup phase so prdata comes from a flop
    logic [7:0] rx_data;
    logic rx_ninth;
    always_comb begin
        case (paddr)
            uart_pkg::OFF_CTRL_TWO: rd_mux = serial_port_control_two;
            uart_pkg::OFF_CTRL_ONE: rd_mux = {global_port_enable, nine_bit_format, 4'h0,
                rx_ninth, 1'b0};
            uart_pkg::OFF_BAUD: rd_mux = baud_divider;
            uart_pkg::OFF_DATA: rd_mux = rx_data;
            uart_pkg::OFF_STATUS: rd_mux = {3'h0, status};
            uart_pkg::OFF_MASK: rd_mux = {3'h0, mask};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, rd_mux};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // baud tick: the counter restarts whenever the port is globally off
    baud_tick_gen #(
        .DIV_W(8)
    ) u_baud (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .clear(~global_port_enable),
        .high_speed(serial_port_control_two.baud_high_speed),
        .divider(baud_divider),
        .tick(baud_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transmit holding register, one word deep; a write while full is dropped
    uart_pkg::line_state_t tx_state;
    logic [8:0] tx_hold;
    logic tx_hold_full;
    logic [8:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [3:0] tx_idx;
    logic tx_load;
    logic tx_bit_end;
    logic tx_idle_ev;
    logic [3:0] bit_last;

    assign bit_last = uart_pkg::data_bits(nine_bit_format) - 4'h1;
    // start only on a tick so the start bit lasts a full sixteen ticks in either range
    assign tx_load = tx_run && tx_state == uart_pkg::LINE_IDLE && tx_hold_full && baud_tick;
    assign tx_bit_end = baud_tick && tx_cnt == uart_pkg::TICK_LAST;
    assign tx_idle_ev = tx_run && tx_state == uart_pkg::LINE_STOP && tx_bit_end && !tx_hold_full;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_hold <= 9'h000;
            tx_hold_full <= 1'b0;
        end else if (!tx_run) begin
            tx_hold_full <= 1'b0;
        end else if (tx_load) begin
            tx_hold_full <= 1'b0;
        end else if (wr && paddr == uart_pkg::OFF_DATA && !tx_hold_full) begin
            tx_hold <= {tx_ninth_bit, pwdata[7:0]};
            tx_hold_full <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state <= uart_pkg::LINE_IDLE;
            tx_shift <= 9'h000;
            tx_cnt <= 4'h0;
            tx_idx <= 4'h0;
            tx_pin <= 1'b1;
        end else if (!tx_run) begin
            tx_state <= uart_pkg::LINE_IDLE;
            tx_cnt <= 4'h0;
            tx_idx <= 4'h0;
            tx_pin <= 1'b1;
        end else begin
            if (baud_tick) begin
                tx_cnt <= tx_cnt + 4'h1;
            end
            case (tx_state)
                uart_pkg::LINE_IDLE: begin
                    tx_cnt <= 4'h0;
                    if (tx_load) begin
                        tx_shift <= tx_hold;
                        tx_state <= uart_pkg::LINE_START;
                        tx_pin <= 1'b0;
                    end
                end
                uart_pkg::LINE_START: begin
                    if (tx_bit_end) begin
                        tx_state <= uart_pkg::LINE_DATA;
                        tx_idx <= 4'h0;
                        tx_pin <= tx_shift[0];
                    end
                end
                uart_pkg::LINE_DATA: begin
                    if (tx_bit_end && tx_idx == bit_last) begin
                        tx_state <= uart_pkg::LINE_STOP;
                        tx_pin <= 1'b1;
                    end else if (tx_bit_end) begin
                        tx_idx <= tx_idx + 4'h1;
                        tx_pin <= tx_shift[tx_idx + 4'h1];
                    end
                end
                uart_pkg::LINE_STOP: begin
                    if (tx_bit_end) begin
                        tx_state <= uart_pkg::LINE_IDLE;
                    end
                end
                default: tx_state <= uart_pkg::LINE_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_pin_oe_n <= 1'b1;
        end else begin
            tx_pin_oe_n <= ~tx_run;
        end
    end
    assign rx_pin_owned = rx_run;

    ////////////////////////////////////////////////////////////////////////////
    // rx pin synchroniser; rx_meta feeds rx_sync only
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
            rx_prev <= rx_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver: start bit checked at mid-bit, data sampled sixteen ticks apart
    uart_pkg::line_state_t rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [3:0] rx_idx;
    logic rx_bit_end;
    logic rx_deliver;
    logic rx_top;
    logic rx_keep;
    logic rx_valid;

    assign rx_bit_end = baud_tick && rx_cnt == uart_pkg::TICK_LAST;
    // a bad stop bit drops the word with no flag
    assign rx_deliver = rx_run && rx_state == uart_pkg::LINE_STOP && rx_bit_end && rx_sync;
    // address bit is the top data bit
    assign rx_top = nine_bit_format ? rx_shift[8] : rx_shift[7];
    assign rx_keep = !(serial_port_control_two.address_detect_enable && !rx_top);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state <= uart_pkg::LINE_IDLE;
            rx_shift <= 9'h000;
            rx_cnt <= 4'h0;
            rx_idx <= 4'h0;
        end else if (!rx_run) begin
            rx_state <= uart_pkg::LINE_IDLE;
            rx_cnt <= 4'h0;
            rx_idx <= 4'h0;
        end else begin
            if (baud_tick) begin
                rx_cnt <= rx_cnt + 4'h1;
            end
            case (rx_state)
                uart_pkg::LINE_IDLE: begin
                    rx_cnt <= 4'h0;
                    if (!rx_sync) begin
                        rx_state <= uart_pkg::LINE_START;
                    end
                end
                uart_pkg::LINE_START: begin
                    if (baud_tick && rx_cnt == uart_pkg::SAMPLE_MID) begin
                        // a short low glitch is not a start bit
                        rx_state <= rx_sync ? uart_pkg::LINE_IDLE : uart_pkg::LINE_DATA;
                        rx_cnt <= 4'h0;
                        rx_idx <= 4'h0;
                        rx_shift <= 9'h000;
                    end
                end
                uart_pkg::LINE_DATA: begin
                    if (rx_bit_end) begin
                        rx_shift[rx_idx] <= rx_sync;
                        if (rx_idx == bit_last) begin
                            rx_state <= uart_pkg::LINE_STOP;
                        end else begin
                            rx_idx <= rx_idx + 4'h1;
                        end
                    end
                end
                uart_pkg::LINE_STOP: begin
                    if (rx_bit_end) begin
                        rx_state <= uart_pkg::LINE_IDLE;
                    end
                end
                default: rx_state <= uart_pkg::LINE_IDLE;
            endcase
        end
    end

    // received word buffer; a new word beats a read in the same cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_data <= 8'h00;
            rx_ninth <= 1'b0;
            rx_valid <= 1'b0;
        end else if (!rx_run) begin
            rx_valid <= 1'b0;
        end else if (rx_deliver && rx_keep) begin
            rx_data <= rx_shift[7:0];
            rx_ninth <= rx_shift[8];
            rx_valid <= 1'b1;
        end else if (rd_data) begin
            rx_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // events gated by the interrupt enables, then sticky, w1c, set wins
    logic wake_ev;
    // wake on falling rx with clock off
    assign wake_ev = serial_port_control_two.rx_wake_enable & port_clock_off & rx_prev & ~rx_sync;

    always_comb begin
        events = '0;
        events[uart_pkg::ST_RX] = rx_deliver & rx_keep &
            serial_port_control_two.receive_irq_enable;
        events[uart_pkg::ST_OVR] = rx_deliver & rx_keep & rx_valid & ~rd_data &
            serial_port_control_two.receive_irq_enable;
        events[uart_pkg::ST_TXE] = tx_load & serial_port_control_two.transmit_empty_irq_enable;
        events[uart_pkg::ST_TXI] = tx_idle_ev & serial_port_control_two.transmit_idle_irq_enable;
        events[uart_pkg::ST_WAKE] = wake_ev & serial_port_control_two.receive_irq_enable;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= uart_pkg::STATUS_RESET;
        end else if (wr && paddr == uart_pkg::OFF_STATUS) begin
            status <= (status & ~pwdata[uart_pkg::ST_W-1:0]) | events;
        end else begin
            status <= status | events;
        end
    end

    assign irq = |(status & mask);

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    logic after_reset;
    logic [10:0] gap_cnt;
    logic gap_ok;
    logic [10:0] gap_expect;
    assign gap_expect = (11'(baud_divider) + 11'h001) * (serial_port_control_two.baud_high_speed
        ? uart_pkg::HIGH_FACTOR : uart_pkg::LOW_FACTOR);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            after_reset <= 1'b0;
            gap_cnt <= 11'h000;
            gap_ok <= 1'b0;
        end else begin
            after_reset <= 1'b1;
            gap_cnt <= baud_tick ? 11'h000 : gap_cnt + 11'h001;
            if (wr || !global_port_enable) begin
                gap_ok <= 1'b0;
            end else if (baud_tick) begin
                gap_ok <= 1'b1;
            end
        end
    end

    sequence rx_fall_s;
        rx_prev && !rx_sync;
    endsequence
    sequence addr_word_s;
        rx_deliver && serial_port_control_two.address_detect_enable && rx_top;
    endsequence

    ctrl_write_a: assert property (
        wr && paddr == uart_pkg::OFF_CTRL_TWO |=> serial_port_control_two == $past(pwdata[7:0]))
        else $error("control two write not stored");
    tx_abort_a: assert property (
        !tx_run |=> tx_state == uart_pkg::LINE_IDLE && !tx_hold_full && tx_pin && tx_pin_oe_n)
        else $error("transmitter not reset on disable");
    tx_owned_a: assert property (
        tx_state != uart_pkg::LINE_IDLE |-> !tx_pin_oe_n && $past(tx_run))
        else $error("transmitter active without both enables");
    rx_abort_a: assert property (
        !rx_run |=> rx_state == uart_pkg::LINE_IDLE && !rx_valid)
        else $error("receiver not reset on disable");
    rx_owned_a: assert property (
        rx_state != uart_pkg::LINE_IDLE |-> $past(rx_run) && $past(rx_pin_owned))
        else $error("receiver active without both enables");
    tick_period_a: assert property (
        baud_tick && gap_ok |-> gap_cnt + 11'h001 == gap_expect)
        else $error("baud tick spacing wrong");
    addr_irq_a: assert property (
        addr_word_s ##0 serial_port_control_two.receive_irq_enable[*1] |=> status[uart_pkg::ST_RX])
        else $error("address word raised no request");
    data_drop_a: assert property (
        rx_deliver && serial_port_control_two.address_detect_enable && !rx_top
        |=> $stable(rx_data) && $stable(rx_ninth))
        else $error("data word not discarded");
    wake_req_a: assert property (
        rx_fall_s ##0 (serial_port_control_two.rx_wake_enable && port_clock_off
        && serial_port_control_two.receive_irq_enable) |=> status[uart_pkg::ST_WAKE])
        else $error("falling rx raised no wake request");
    ctrl_reset_a: assert property (
        !after_reset |-> serial_port_control_two == uart_pkg::CTRL_TWO_RESET)
        else $error("control bits not clear after reset");

endmodule : uart_txrx_enable_addr_detect
`default_nettype wire

// ===== test/remote_node.sv
// remote serial node model facing the tx and rx pins of the port
`timescale 1ns/1ns
`default_nettype none
module remote_node (
    input wire logic core_clk,
    input wire logic tx_pin,
    output logic rx_pin
);
    // the node holds its line at the idle mark level between frames
    initial rx_pin = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // one frame towards the port: start, eight data bits lsb first, one stop
    task automatic send(input logic [7:0] b, input int bit_cycles);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        // frames start on a rising edge, whatever the caller last waited for
        @(posedge core_clk);
        for (int i = 0; i < 10; i++) begin
            rx_pin <= frame[i];
            repeat (bit_cycles) @(posedge core_clk);
        end
    endtask : send

    // one frame from the port; start length gives the real bit period
    task automatic recv(input int bit_cycles, output logic [7:0] b, output int start_len);
        start_len = 0;
        while (tx_pin !== 1'b0) @(posedge core_clk);
        while (tx_pin === 1'b0) begin
            start_len++;
            @(posedge core_clk);
        end
        // sample mid bit, away from the edges
        repeat (bit_cycles / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            b[i] = tx_pin;
            repeat (bit_cycles) @(posedge core_clk);
        end
    endtask : recv
endmodule : remote_node
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the serial port control block over apb
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr, port_clock_off, rx_pin;
    logic rx_pin_owned, tx_pin, tx_pin_oe_n, irq, last_err;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    int fail_count, check_count, len;

    uart_txrx_enable_addr_detect i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_clock_off(port_clock_off), .rx_pin(rx_pin), .rx_pin_owned(rx_pin_owned),
        .tx_pin(tx_pin), .tx_pin_oe_n(tx_pin_oe_n), .irq(irq));
    remote_node i_node (.core_clk(core_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // callers look at outputs only once the edge's updates have settled
        @(negedge core_clk);
    endtask : apb

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // frames total a few thousand cycles; far beyond that means a hang
    initial begin
        repeat (30000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end

    initial begin
        {reset_n, psel, penable, pwrite, port_clock_off} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        apb(1'b0, uart_pkg::OFF_CTRL_TWO, 32'h0);
        chk("ctrl_two_reset", q, 32'h0);
        chk("tx_oe_reset", {31'h0, tx_pin_oe_n}, 32'h1);
        apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'hA5);
        apb(1'b0, uart_pkg::OFF_CTRL_TWO, 32'h0);
        chk("ctrl_two_rw", q, 32'hA5);
        apb(1'b0, 8'h3C, 32'h0);
        chk("unmapped_err", {31'h0, last_err}, 32'h1);
        // bits set but global enable still off: pins stay with the pin mux
        apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'hFC);
        apb(1'b1, uart_pkg::OFF_BAUD, 32'h0);
        apb(1'b1, uart_pkg::OFF_MASK, 32'h1);
        chk("rx_owned_gated", {31'h0, rx_pin_owned}, 32'h0);
        chk("tx_oe_gated", {31'h0, tx_pin_oe_n}, 32'h1);
        apb(1'b1, uart_pkg::OFF_CTRL_ONE, 32'h80);
        repeat (2) @(posedge core_clk);
        chk("rx_owned", {31'h0, rx_pin_owned}, 32'h1);
        chk("tx_oe", {31'h0, tx_pin_oe_n}, 32'h0);
        fork
            apb(1'b1, uart_pkg::OFF_DATA, 32'h5B);
            i_node.recv(16, b, len);
        join
        chk("tx_byte", {24'h0, b}, 32'h5B);
        chk("bit_high", len, 32'd16);
        repeat (40) @(posedge core_clk);
        // a data word under address detection leaves no trace
        i_node.send(8'h35, 16);
        repeat (10) @(posedge core_clk);
        apb(1'b0, uart_pkg::OFF_STATUS, 32'h0);
        chk("data_dropped", q, 32'h0);
        chk("irq_quiet", {31'h0, irq}, 32'h0);
        i_node.send(8'hA3, 16);
        repeat (10) @(posedge core_clk);
        apb(1'b0, uart_pkg::OFF_STATUS, 32'h0);
        chk("addr_event", q, 32'h1);
        chk("irq_addr", {31'h0, irq}, 32'h1);
        apb(1'b0, uart_pkg::OFF_DATA, 32'h0);
        chk("addr_word", q, 32'hA3);
        apb(1'b1, uart_pkg::OFF_STATUS, 32'h1F);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        // receiver switched off mid frame must lose the word
        fork
            i_node.send(8'hFF, 16);
            begin
                repeat (60) @(posedge core_clk);
                apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'hBC);
                chk("rx_released", {31'h0, rx_pin_owned}, 32'h0);
                apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'hFC);
            end
        join
        repeat (10) @(posedge core_clk);
        apb(1'b0, uart_pkg::OFF_STATUS, 32'h0);
        chk("rx_aborted", q, 32'h0);
        // transmitter switched off mid frame: line back to mark, buffer gone
        apb(1'b1, uart_pkg::OFF_DATA, 32'h0);
        repeat (40) @(posedge core_clk);
        apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'h7C);
        repeat (2) @(posedge core_clk);
        chk("tx_abort_pin", {tx_pin, tx_pin_oe_n}, 32'h3);
        apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'hFC);
        repeat (30) @(posedge core_clk);
        chk("tx_flushed", {31'h0, tx_pin}, 32'h1);
        // falling rx edge with the serial clock off requests wake
        port_clock_off <= 1'b1;
        i_node.send(8'hFF, 16);
        repeat (10) @(posedge core_clk);
        apb(1'b0, uart_pkg::OFF_STATUS, 32'h0);
        chk("wake_event", q & 32'h8, 32'h8);
        // wake bit off: the same falling edge must stay silent
        apb(1'b1, uart_pkg::OFF_STATUS, 32'h1F);
        apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'hF4);
        i_node.send(8'h7F, 16);
        repeat (10) @(posedge core_clk);
        port_clock_off <= 1'b0;
        apb(1'b0, uart_pkg::OFF_STATUS, 32'h0);
        chk("wake_off", q, 32'h0);
        apb(1'b1, uart_pkg::OFF_CTRL_TWO, 32'hDC);
        fork
            apb(1'b1, uart_pkg::OFF_DATA, 32'h5B);
            i_node.recv(64, b, len);
        join
        chk("bit_low", len, 32'd64);
        chk("tx_byte_low", {24'h0, b}, 32'h5B);
        stop_test();
    end
endmodule : tb
`default_nettype wire
